// *** dv/fpec_flash_model.sv ***
// Behavioural flash array that answers the controller's start pulses
`timescale 1ns/10ps
`default_nettype none
module fpec_flash_model #(
  parameter int         BUSY_CYC = 6,    // Cycles one operation stays busy
  parameter logic [7:0] OPT_INIT = 8'h10 // Option bytes held at power-up
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        prog_i,
  input  wire logic        perase_i,
  input  wire logic        merase_i,
  output var  logic [7:0]  rdata_o,
  output var  logic        busy_o
);
  logic [7:0] mem [2] = '{OPT_INIT, ~OPT_INIT}; // Option cells, distinct, kept over reset
  int         cnt;                            // Remaining busy cycles
  // Busy span restarts on every start pulse, pins or controller alike
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      cnt <= 0;
    else if (prog_i | perase_i | merase_i)
      cnt <= BUSY_CYC;
    else if (cnt > 0)
      cnt <= cnt - 1;
  assign busy_o = (cnt != 0);
  // Contents and registered read; unmodelled cells give a moving pattern
  always @(posedge clk_i)
  begin
    rdata_o <= (addr_i < 16'h0002) ? mem[addr_i[0]] : ~addr_i[7:0];
    if (prog_i && addr_i < 16'h0002)
      mem[addr_i[0]] <= wdata_i;
    if (merase_i || (perase_i && addr_i[15:9] == 7'h00))
      mem <= '{8'hFF, 8'hFF};
  end
endmodule : fpec_flash_model
`default_nettype wire

// *** dv/fpec_top_tb.sv ***
// Self-checking bench for the flash program/erase controller
`timescale 1ns/10ps
`default_nettype none
module fpec_top_tb;
  typedef struct packed {
    logic        dbg; // Debugger access
    logic [11:0] wa;  // Write address
    logic [7:0]  wd;  // Write data
    logic [11:0] ra;  // Read-back address
    logic [15:0] ex;  // Expected read-back
  } fpec_row_t;
  logic                clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                dbg = 1'b0, bypass = 1'b0, pready, pslverr, hold, fprog, fper, fmer, fbusy, er;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = 32'h0, prdata, rd;
  fpec_pkg::fpec_gpio_t gp = '0;
  fpec_pkg::fpec_opt_t opt;
  logic [15:0]         fa, cap_a;
  logic [7:0]          fwd, frd, cap_d;
  int                  errors = 0, checks_done = 0, n_prog = 0, n_per = 0, n_mer = 0, k;
  fpec_row_t rows [26] = '{
    '{0,12'hFF8,8'h73,12'hFF8,16'h0001}, '{0,12'hFF8,8'h8C,12'hFF8,16'h0002},
    '{0,12'hFFC,8'h03,12'hFF8,16'h0003}, '{0,12'hFFC,8'h07,12'hFFC,16'h0003},
    '{0,12'hFF8,8'h5E,12'hFF8,16'h0004}, '{0,12'hFFC,8'h02,12'hFFC,16'h0203},
    '{0,12'hFF8,8'h73,12'hFF8,16'h0001}, '{0,12'hFF8,8'h55,12'hFF8,16'h0000},
    '{0,12'hFF8,8'h73,12'hFF8,16'h0001}, '{0,12'hFF8,8'h8C,12'hFF8,16'h0002},
    '{0,12'hFF8,8'h8C,12'hFF8,16'h0000}, '{0,12'hFF8,8'h73,12'hFF8,16'h0001},
    '{0,12'hFF8,8'h8C,12'hFF8,16'h0002}, '{0,12'hFFC,8'h01,12'hFF8,16'h0003},
    '{0,12'hFF8,8'h5E,12'hFF8,16'h0004}, '{0,12'hFFC,8'h00,12'hFFC,16'h0201},
    '{0,12'hFF8,8'h73,12'hFF8,16'h0001}, '{0,12'hFF8,8'h8C,12'hFF8,16'h0002},
    '{0,12'hFFC,8'h01,12'hFF8,16'h0003}, '{0,12'hFF8,8'h63,12'hFF8,16'h0000},
    '{1,12'hFF8,8'h73,12'hFF8,16'h0001}, '{1,12'hFF8,8'h8C,12'hFF8,16'h0003},
    '{1,12'hFFC,8'h05,12'hFFC,16'h0205}, '{1,12'hFF8,8'h5E,12'hFF8,16'h0004},
    '{1,12'hFFC,8'h04,12'hFFC,16'h0405}, '{1,12'hFF8,8'h12,12'hFF8,16'h0000}};
  // 25 MHz system clock
  always #20 clk = ~clk;
  fpec_top DUT (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .DBG_ACCESS_I(dbg), .CPU_HOLD_O(hold), .BYPASS_I(bypass), .GP_I(gp), .FL_ADDR_O(fa),
    .FL_WDATA_O(fwd), .FL_PROG_O(fprog), .FL_PERASE_O(fper), .FL_MERASE_O(fmer),
    .FL_RDATA_I(frd), .FL_BUSY_I(fbusy), .OPT_O(opt));
  fpec_flash_model partner (.clk_i(clk), .rst_n_i(rst_n), .addr_i(fa), .wdata_i(fwd), .prog_i(fprog),
    .perase_i(fper), .merase_i(fmer), .rdata_o(frd), .busy_o(fbusy));
  // Counts start pulses and keeps the last target
  always @(posedge clk)
  begin
    if (fprog)
    begin
      n_prog++;
      cap_a = fa;
      cap_d = fwd;
    end
    if (fper)
    begin
      n_per++;
      cap_a = fa;
    end
    if (fmer)
      n_mer++;
  end
  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; waits for the answer, keeps read data and error
  task automatic apb(input logic d, input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    dbg     <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Waits as long as the slave needs; the watchdog ends a hang
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    dbg     <= 1'b0;
  endtask : apb
  task automatic wr(input logic d, input logic [11:0] a, input logic [15:0] v);
    apb(d, 1'b1, a, {16'h0, v});
  endtask : wr
  // Polls status until the code shows, bounded
  task automatic wait_st(input logic [7:0] e);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 1'b0, fpec_pkg::STAT_CTL_ADDR, 32'h0);
      n++;
    end
    while (rd !== {24'h0, e} && n < 40);
    chk(rd, {24'h0, e});
  endtask : wait_st
  task automatic unlock(input logic d, input logic [7:0] pg);
    wr(d, 12'hFF8, 16'h0073);
    wr(d, 12'hFF8, 16'h008C);
    wr(d, 12'hFFC, {8'h00, pg});
  endtask : unlock
  task automatic prog(input logic d, input logic [15:0] a, input logic [7:0] v);
    wr(d, 12'hFF0, a);
    wr(d, 12'hFF4, {8'h00, v});
  endtask : prog
  // Reset, then option load must finish before the processor runs
  task automatic rst(input logic [15:0] eo);
    int n;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk(hold, 1'b1);
    rst_n <= 1'b1;
    n = 0;
    while (hold !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk(opt, eo);
    chk(hold, 1'b0);
    $display("reset test done");
  endtask : rst
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // Main sequence
  initial
  begin
    rst(16'h10EF);
    wait_st(8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].dbg, rows[i].wa, {8'h00, rows[i].wd});
      apb(1'b0, 1'b0, rows[i].ra, 32'h0);
      chk(rd, {16'h0, rows[i].ex});
    end
    chk(n_mer, 0);
    $display("table test done");
    k = n_prog;
    unlock(1'b0, 8'h00);
    prog(1'b0, 16'h0003, 8'hC3);
    wait_st(8'h03);
    chk(n_prog, k);
    prog(1'b1, 16'h4000, 8'hA5);
    wait_st(8'h08);
    wait_st(8'h03);
    chk({cap_a, cap_d}, 32'h004000A5);
    chk(n_prog, k + 1);
    wr(1'b1, 12'hFFC, 16'h0005);
    wr(1'b1, 12'hFF8, 16'h0095);
    wait_st(8'h10);
    wait_st(8'h00);
    chk(n_per, 1);
    chk(cap_a, 16'h0A00);
    $display("program and page erase test done");
    unlock(1'b1, 8'h00);
    wr(1'b1, 12'hFF8, 16'h0063);
    wait_st(8'h20);
    chk(hold, 1'b1);
    wait_st(8'h00);
    repeat (2) @(posedge clk);
    chk({hold, n_mer[7:0]}, {1'b0, 8'h01});
    unlock(1'b1, 8'h00);
    prog(1'b1, 16'h0000, 8'h00);
    wait_st(8'h03);
    prog(1'b1, 16'h0001, 8'h00);
    wait_st(8'h03);
    chk(opt, 16'h10EF);
    rst(16'h0000);
    k = n_prog;
    unlock(1'b0, 8'h00);
    prog(1'b0, 16'h01FF, 8'h3C);
    wait_st(8'h03);
    prog(1'b0, 16'h0200, 8'h3C);
    wait_st(8'h03);
    chk(n_prog - k, 1);
    chk(cap_a, 16'h01FF);
    apb(1'b0, 1'b0, 12'h100, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("mass erase, option and refusal test done");
    @(posedge clk);
    gp     <= '{addr: 16'h1234, data: 8'h5A, prog: 1'b1, perase: 1'b0};
    bypass <= 1'b1;
    repeat (4) @(posedge clk);
    chk({fa, fwd, fprog, fper}, {16'h1234, 8'h5A, 2'b10});
    gp.prog   <= 1'b0;
    gp.perase <= 1'b1;
    repeat (4) @(posedge clk);
    chk({fa, fprog, fper}, {16'h1234, 2'b01});
    bypass <= 1'b0;
    gp     <= '0;
    $display("bypass test done");
    test_done();
  end
  // Watchdog on a hung run
  initial
  begin
    #800000;
    errors++;
    test_done();
  end
endmodule : fpec_top_tb
`default_nettype wire

// *** src/fpec_opt_load.sv ***
// Option byte loader run once after reset
`timescale 1ns/10ps
`default_nettype none
module fpec_opt_load (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [7:0]        rdata_i,
  output var  logic [15:0]       addr_o,
  output var  fpec_pkg::fpec_opt_t opt_o,
  output var  logic              done_o
);
  logic [2:0] step; // Load sequence position

  // Walk two option bytes; address passes the array output flop, data the array read flop
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      step   <= 3'h0;
      addr_o <= fpec_pkg::OPT_ADDR0;
      opt_o  <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      case (step)
        3'h0:
        begin
          addr_o <= fpec_pkg::OPT_ADDR1; // Byte 0 address on its way out
          step   <= 3'h1;
        end
        3'h1:
        begin
          step <= 3'h2; // Byte 0 read under way in the array
        end
        3'h2:
        begin
          opt_o[15:8] <= rdata_i; // Byte 0 captured
          step        <= 3'h3;
        end
        3'h3:
        begin
          opt_o[7:0] <= rdata_i; // Byte 1 captured
          done_o     <= 1'b1;
          step       <= 3'h4;
        end
        default:
        begin
          step <= 3'h4; // Holding registers frozen until reset
        end
      endcase
    end
  end

  // Loading finishes four edges after release
  a_load_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (step == 3'h0) |-> ##4 done_o)
    else $error("option load did not finish");
  // Holding registers never change after loading
  a_opt_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_o |=> (done_o && $stable(opt_o)))
    else $error("option registers changed after load");
endmodule : fpec_opt_load
`default_nettype wire

// *** src/fpec_pkg.sv ***
// Constants, states and carriers for the flash program/erase controller
// Notes on behaviour
// - Mass-erase code in control starts array erase
// - Processor held during mass erase, clock runs
// - Mass erase end relocks the controller
// - Bypass routes array controls to general pins
// - Bypass supports page erase and row programming
// - Debugger ignores write-protect option bit
// - Debugger ignores sector protection bits
// - Debugger programs any address, any page
// - Debugger sets and clears sector bits freely
// - Debugger unlock skips second page select
// - Debugger may rewrite page select when unlocked
// - Mass erase accepted only from debugger
// - One processor unlock opens exactly one page
// - Status reads, control writes, same address
// - Six-bit state code, upper bits zero
// - Unlock keys in order, codes 1,2,3
// - Busy codes: program, page erase, mass erase
// - Page select shares address with sector protect
// - 512-byte page chosen by upper seven bits
// - Option bytes copied to holding registers at reset
// - Options load before processor runs
// - Option holding registers not software reachable
package fpec_pkg;
  // Register byte addresses
  localparam logic [11:0] STAT_CTL_ADDR  = 12'hFF8;
  localparam logic [11:0] PAGE_SECT_ADDR = 12'hFFC;
  localparam logic [11:0] PROG_ADDR_ADDR = 12'hFF0;
  localparam logic [11:0] PROG_DATA_ADDR = 12'hFF4;
  // Control register codes
  localparam logic [7:0] KEY_FIRST  = 8'h73;
  localparam logic [7:0] KEY_SECOND = 8'h8C;
  localparam logic [7:0] CMD_MASS   = 8'h63;
  localparam logic [7:0] CMD_SECT   = 8'h5E;
  localparam logic [7:0] CMD_PAGE   = 8'h95;
  // Reset values
  localparam logic [7:0]  PAGE_RST = 8'h00;
  localparam logic [7:0]  SECT_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // Address field positions
  localparam int PAGE_LSB = 9;
  localparam int SECT_LSB = 13;
  // Option byte locations in program flash
  localparam logic [15:0] OPT_ADDR0 = 16'h0000;
  localparam logic [15:0] OPT_ADDR1 = 16'h0001;
  // Controller states; the code is the status field
  typedef enum logic [5:0] {
    FC_LOCKED   = 6'b000000,
    FC_FIRST    = 6'b000001,
    FC_SECOND   = 6'b000010,
    FC_UNLOCKED = 6'b000011,
    FC_SECT     = 6'b000100,
    FC_PROG     = 6'b001000,
    FC_PERASE   = 6'b010000,
    FC_MERASE   = 6'b100000
  } fpec_state_t;
  // Pins used while the controller is bypassed
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        prog;
    logic        perase;
  } fpec_gpio_t;
  // Option holding registers
  typedef struct packed {
    logic       wdt_int_sel;
    logic       wdt_always_on;
    logic       read_prot;
    logic       write_prot;
    logic       bod_stop_en;
    logic [2:0] osc_mode;
    logic [7:0] trim;
  } fpec_opt_t;
endpackage : fpec_pkg

// *** src/fpec_top.sv ***
// Flash program/erase controller with APB register access
`timescale 1ns/10ps
`default_nettype none
module fpec_top (
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [11:0]       PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output var  logic [31:0]       PRDATA_O,
  output var  logic              PREADY_O,
  output var  logic              PSLVERR_O,
  input  wire logic              DBG_ACCESS_I,
  output var  logic              CPU_HOLD_O,
  input  wire logic              BYPASS_I,
  input  wire fpec_pkg::fpec_gpio_t GP_I,
  output var  logic [15:0]       FL_ADDR_O,
  output var  logic [7:0]        FL_WDATA_O,
  output var  logic              FL_PROG_O,
  output var  logic              FL_PERASE_O,
  output var  logic              FL_MERASE_O,
  input  wire logic [7:0]        FL_RDATA_I,
  input  wire logic              FL_BUSY_I,
  output var  fpec_pkg::fpec_opt_t OPT_O
);
  fpec_pkg::fpec_state_t state;    // Controller state
  logic [7:0]            page;     // erase_page_selector
  logic [7:0]            sect;     // Sector protect bits
  logic [15:0]           prog_addr; // Program target
  logic [7:0]            prog_data; // Program byte
  logic                  seen_busy; // Array busy seen
  logic [26:0]           pin_meta; // First sync stage
  logic [26:0]           pin_sync; // Second sync stage
  logic                  byp;      // Synced bypass level
  fpec_pkg::fpec_gpio_t  gp;       // Synced bypass pins
  logic [15:0]           ld_addr;  // Loader read address
  logic                  ld_done;  // Options loaded
  logic                  acc;      // APB access edge
  logic                  wr;       // Write taken
  logic                  ctl_wr;   // Control write
  logic                  ps_wr;    // Page/sector write
  logic                  pa_wr;    // Program address write
  logic                  pd_wr;    // Program data write
  logic [7:0]            cmd;      // Written byte
  logic                  dbg;      // Debugger access
  logic                  in_op;    // Operation running
  logic                  op_done;  // Operation finished
  logic                  go_prog;  // Program accepted
  logic                  go_page;  // Page erase accepted
  logic                  go_mass;  // Mass erase accepted
  logic [15:0]           page_base; // Erase page address

  // Protection check; debugger bypasses both gates
  function automatic logic fpec_allow(
    input logic [15:0] addr,
    input logic        from_dbg,
    input logic        wprot,
    input logic [7:0]  sbits
  );
    logic [2:0] sidx;
    sidx = addr[fpec_pkg::SECT_LSB +: 3];
    fpec_allow = from_dbg || (!wprot && !sbits[sidx]);
  endfunction : fpec_allow

  // Option bytes captured before the core runs
  fpec_opt_load u_opt (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .rdata_i (FL_RDATA_I),
    .addr_o  (ld_addr),
    .opt_o   (OPT_O),
    .done_o  (ld_done)
  );

  // Pin synchroniser for bypass inputs
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {BYPASS_I, GP_I};
      pin_sync <= pin_meta;
    end
  end

  // Decode of the taken access
  always_comb
  begin
    byp       = pin_sync[26];
    gp        = pin_sync[25:0];
    acc       = PSEL_I && PENABLE_I && PREADY_O;
    wr        = acc && PWRITE_I;
    cmd       = PWDATA_I[7:0];
    dbg       = DBG_ACCESS_I;
    ctl_wr    = wr && (PADDR_I == fpec_pkg::STAT_CTL_ADDR);
    ps_wr     = wr && (PADDR_I == fpec_pkg::PAGE_SECT_ADDR);
    pa_wr     = wr && (PADDR_I == fpec_pkg::PROG_ADDR_ADDR);
    pd_wr     = wr && (PADDR_I == fpec_pkg::PROG_DATA_ADDR);
    in_op     = (state == fpec_pkg::FC_PROG) || (state == fpec_pkg::FC_PERASE) ||
                (state == fpec_pkg::FC_MERASE);
    op_done   = in_op && seen_busy && !FL_BUSY_I;
    page_base = {page[6:0], 9'h000};
    go_prog   = pd_wr && (state == fpec_pkg::FC_UNLOCKED) && !byp &&
                (dbg || (prog_addr[15:fpec_pkg::PAGE_LSB] == page[6:0])) &&
                fpec_allow(prog_addr, dbg, OPT_O.write_prot, sect);
    go_page   = ctl_wr && (cmd == fpec_pkg::CMD_PAGE) && !byp &&
                (state == fpec_pkg::FC_UNLOCKED) &&
                fpec_allow(page_base, dbg, OPT_O.write_prot, sect);
    go_mass   = ctl_wr && (cmd == fpec_pkg::CMD_MASS) && dbg && !byp &&
                (state == fpec_pkg::FC_UNLOCKED) && !OPT_O.write_prot | dbg;
  end

  // Unlock and operation sequencer
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state <= fpec_pkg::FC_LOCKED;
    end
    else if (byp || !ld_done)
    begin
      state <= fpec_pkg::FC_LOCKED; // Controller idle while bypassed
    end
    else
    begin
      case (state)
        fpec_pkg::FC_LOCKED:
        begin
          if (ctl_wr && (cmd == fpec_pkg::KEY_FIRST))
            state <= fpec_pkg::FC_FIRST;
        end
        fpec_pkg::FC_FIRST:
        begin
          if (ctl_wr && (cmd == fpec_pkg::KEY_SECOND))
            state <= dbg ? fpec_pkg::FC_UNLOCKED : fpec_pkg::FC_SECOND;
          else if (ctl_wr)
            state <= fpec_pkg::FC_LOCKED; // Wrong key
        end
        fpec_pkg::FC_SECOND:
        begin
          if (ps_wr)
            state <= fpec_pkg::FC_UNLOCKED; // Page select completes unlock
          else if (ctl_wr)
            state <= fpec_pkg::FC_LOCKED;
        end
        fpec_pkg::FC_UNLOCKED:
        begin
          if (go_mass)
            state <= fpec_pkg::FC_MERASE;
          else if (go_page)
            state <= fpec_pkg::FC_PERASE;
          else if (go_prog)
            state <= fpec_pkg::FC_PROG;
          else if (ctl_wr && (cmd == fpec_pkg::CMD_SECT))
            state <= fpec_pkg::FC_SECT;
          else if (ctl_wr)
            state <= fpec_pkg::FC_LOCKED; // Refused command relocks
        end
        fpec_pkg::FC_SECT:
        begin
          if (ps_wr || ctl_wr)
            state <= fpec_pkg::FC_LOCKED;
        end
        fpec_pkg::FC_PROG:
        begin
          if (op_done)
            state <= fpec_pkg::FC_UNLOCKED; // Same page stays open
        end
        fpec_pkg::FC_PERASE:
        begin
          if (op_done)
            state <= fpec_pkg::FC_LOCKED; // Page used up
        end
        fpec_pkg::FC_MERASE:
        begin
          if (op_done)
            state <= fpec_pkg::FC_LOCKED;
        end
        default:
        begin
          state <= fpec_pkg::FC_LOCKED;
        end
      endcase
    end
  end

  // Array busy tracking for the running operation
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      seen_busy <= 1'b0;
    else if (!in_op || op_done)
      seen_busy <= 1'b0;
    else if (FL_BUSY_I)
      seen_busy <= 1'b1;
  end

  // Page select and sector protect, shared address
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      page <= fpec_pkg::PAGE_RST;
      sect <= fpec_pkg::SECT_RST;
    end
    else if (ps_wr && (state == fpec_pkg::FC_SECT))
    begin
      sect <= dbg ? cmd : (sect | cmd);
    end
    else if (ps_wr && !in_op && ((state != fpec_pkg::FC_UNLOCKED) || dbg))
    begin
      page <= cmd;
    end
  end

  // Program address and data holding
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      prog_addr <= fpec_pkg::ADDR_RST;
      prog_data <= 8'h00;
    end
    else
    begin
      if (pa_wr && !in_op)
        prog_addr <= PWDATA_I[15:0];
      if (pd_wr && !in_op)
        prog_data <= cmd;
    end
  end

  // Array control outputs, controller or bypass pins
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      FL_ADDR_O   <= fpec_pkg::ADDR_RST;
      FL_WDATA_O  <= 8'h00;
      FL_PROG_O   <= 1'b0;
      FL_PERASE_O <= 1'b0;
      FL_MERASE_O <= 1'b0;
    end
    else if (byp)
    begin
      FL_ADDR_O   <= gp.addr;
      FL_WDATA_O  <= gp.data;
      FL_PROG_O   <= gp.prog; // Row programming from pins
      FL_PERASE_O <= gp.perase; // Page erase from pins
      FL_MERASE_O <= 1'b0;
    end
    else if (!ld_done)
    begin
      FL_ADDR_O   <= ld_addr; // Option fetch
      FL_PROG_O   <= 1'b0;
      FL_PERASE_O <= 1'b0;
      FL_MERASE_O <= 1'b0;
    end
    else
    begin
      FL_PROG_O   <= go_prog;
      FL_PERASE_O <= go_page;
      FL_MERASE_O <= go_mass;
      if (go_prog)
      begin
        FL_ADDR_O  <= prog_addr;
        FL_WDATA_O <= cmd; // Byte of this data write, prog_data lags one edge
      end
      else if (go_page)
      begin
        FL_ADDR_O <= page_base;
      end
    end
  end

  // Processor hold during load and mass erase
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      CPU_HOLD_O <= 1'b1; // Held until options loaded
    else
      CPU_HOLD_O <= !ld_done || go_mass ||
                    ((state == fpec_pkg::FC_MERASE) && !op_done);
  end

  // APB slave, zero wait, data staged in setup
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end
    else if (PSEL_I && !PENABLE_I)
    begin
      PREADY_O  <= 1'b1;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      case (PADDR_I)
        fpec_pkg::STAT_CTL_ADDR:
          if (!PWRITE_I)
            PRDATA_O <= {26'h0000000, state};
        fpec_pkg::PAGE_SECT_ADDR:
          if (!PWRITE_I)
            PRDATA_O <= {16'h0000, sect, page};
        fpec_pkg::PROG_ADDR_ADDR:
          if (!PWRITE_I)
            PRDATA_O <= {16'h0000, prog_addr};
        fpec_pkg::PROG_DATA_ADDR:
          if (!PWRITE_I)
            PRDATA_O <= {24'h000000, prog_data};
        default:
          PSLVERR_O <= 1'b1; // Unmapped address
      endcase
    end
    else
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Two keys written in order
  sequence s_keys;
    (ctl_wr && (cmd == fpec_pkg::KEY_FIRST) && (state == fpec_pkg::FC_LOCKED) && ld_done && !byp)
    ##[1:20] (ctl_wr && (cmd == fpec_pkg::KEY_SECOND) && (state == fpec_pkg::FC_FIRST) &&
              ld_done && !byp);
  endsequence

  a_key_order: assert property (s_keys |=> ((state == fpec_pkg::FC_SECOND) ||
    (state == fpec_pkg::FC_UNLOCKED)))
    else $error("unlock keys did not advance");
  a_dbg_unlock: assert property ((s_keys ##0 dbg) |=> (state == fpec_pkg::FC_UNLOCKED))
    else $error("debugger unlock needed page select");
  a_bad_key: assert property ((state == fpec_pkg::FC_SECOND) && ctl_wr && !byp && ld_done
    |=> (state == fpec_pkg::FC_LOCKED))
    else $error("wrong key did not relock");
  a_mass_cpu: assert property (ctl_wr && (cmd == fpec_pkg::CMD_MASS) && !dbg
    |=> (state != fpec_pkg::FC_MERASE))
    else $error("processor started mass erase");
  a_mass_hold: assert property ((state == fpec_pkg::FC_MERASE) && !op_done
    |=> CPU_HOLD_O)
    else $error("processor not held in mass erase");
  a_mass_relock: assert property ((state == fpec_pkg::FC_MERASE) && op_done && !byp
    |=> (state == fpec_pkg::FC_LOCKED))
    else $error("mass erase end did not relock");
  a_page_relock: assert property ((state == fpec_pkg::FC_PERASE) && op_done && !byp
    |=> (state == fpec_pkg::FC_LOCKED))
    else $error("page erase end did not relock");
  a_sect_keep: assert property ((state == fpec_pkg::FC_SECT) && ps_wr && !dbg
    |=> ((sect & $past(sect)) == $past(sect)))
    else $error("processor cleared a sector bit");
  a_stat_read: assert property (PREADY_O && !PWRITE_I && (PADDR_I == fpec_pkg::STAT_CTL_ADDR)
    |-> (PRDATA_O[31:6] == 26'h0000000))
    else $error("status upper bits not zero");
  a_prog_code: assert property (go_prog |=> FL_PROG_O ##1 (PRDATA_O[5:3] == 3'h1 || !PREADY_O || PWRITE_I ||
    PADDR_I != fpec_pkg::STAT_CTL_ADDR))
    else $error("program not flagged in status");
  a_bypass_out: assert property (byp |=> (FL_ADDR_O == $past(gp.addr)) && !FL_MERASE_O)
    else $error("bypass pins not routed to array");
endmodule : fpec_top
`default_nettype wire
